// ==== src/dclim_pkg.sv ====
// shared constants for the dual channel limit alert block
package dclim_pkg;
  // register word indices as printed; byte address is four times the index
  localparam logic [3:0] IDX_FLAGS = 4'h3;
  localparam logic [3:0] IDX_LOWER = 4'h4;
  localparam logic [3:0] IDX_UPPER = 4'h5;
  localparam logic [3:0] IDX_CTRL = 4'h2;
  localparam logic [3:0] IDX_IRQ_MASK = 4'h6;
  localparam logic [11:0] ADDR_FLAGS = {6'h00, IDX_FLAGS, 2'h0};
  localparam logic [11:0] ADDR_LOWER = {6'h00, IDX_LOWER, 2'h0};
  localparam logic [11:0] ADDR_UPPER = {6'h00, IDX_UPPER, 2'h0};
  localparam logic [11:0] ADDR_CTRL = {6'h00, IDX_CTRL, 2'h0};
  localparam logic [11:0] ADDR_IRQ_MASK = {6'h00, IDX_IRQ_MASK, 2'h0};
  // flag bit positions
  localparam int BIT_A_UNDER = 0;
  localparam int BIT_A_OVER = 1;
  localparam int BIT_B_UNDER = 4;
  localparam int BIT_B_OVER = 5;
  localparam logic [15:0] FLAG_MASK = 16'h0033;
  // reset values
  localparam logic [15:0] LOWER_RESET = 16'h0800;
  localparam logic [15:0] UPPER_RESET = 16'h07ff;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  // threshold widening
  localparam logic [3:0] LOWER_FILL = 4'h0;
  localparam logic [3:0] UPPER_FILL = 4'hf;
  localparam logic [7:0] SOFT_RESET_CODE = 8'h3c;
endpackage

// ==== src/dclim_compare.sv ====
// per-channel limit comparator producing one-cycle over and under events
`timescale 1ns/1ps
`default_nettype none
module dclim_compare #(
  parameter int WIDTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic valid,
  input wire logic [WIDTH-1:0] result,
  input wire logic [WIDTH-1:0] low_thr,
  input wire logic [WIDTH-1:0] high_thr,
  output logic under_evt,
  output logic over_evt
);
  if (WIDTH != 16)
  begin : g_bad_width
    $error("dclim_compare: width must be 16");
  end
  logic next_under;
  logic next_over;
  always_comb
  begin
    next_under = valid && (result < low_thr);
    next_over = valid && (result > high_thr);
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      under_evt <= 1'b0;
      over_evt <= 1'b0;
    end
    else
    begin
      under_evt <= next_under;
      over_evt <= next_over;
    end
  end
  property p_under_cause;
    @(posedge pclk) disable iff (!presetn)
    under_evt |-> $past(valid) && ($past(result) < $past(low_thr));
  endproperty
  a_under_cause: assert property (p_under_cause)
    else $error("under event without low crossing");
  property p_over_cause;
    @(posedge pclk) disable iff (!presetn)
    over_evt |-> $past(valid) && ($past(result) > $past(high_thr));
  endproperty
  a_over_cause: assert property (p_over_cause)
    else $error("over event without high crossing");
endmodule // dclim_compare
`default_nettype wire

// ==== src/dclim_top.sv ====
// apb register bank and sticky alert flags for two conversion channels
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
//
// Function
// - channel B result above high threshold sets channel B over flag.
// - channel B result below low threshold sets channel B under flag.
// - channel A result above high threshold sets channel A over flag.
// - channel A result below low threshold sets channel A under flag.
// - flags stay set until the flag register is read or the soft reset code is written, either of which clears them.
// - low field fills threshold bits 15..4, low nibble zero.
// - under alert when result below low threshold, none above it.
// - high field fills threshold bits 15..4, low nibble all ones.
// - over alert when result above high threshold, none below it.
// - lower limit register resets to 0x0800.
// - upper limit register resets to 0x07ff.
// - top nibble of threshold registers is written and read back.
// - soft reset code clears all flags, keeps threshold contents.
module dclim_top #(
  parameter int RES_WIDTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic a_valid,
  input wire logic [RES_WIDTH-1:0] a_result,
  input wire logic b_valid,
  input wire logic [RES_WIDTH-1:0] b_result,
  output logic irq
);
  if (RES_WIDTH != 16)
  begin : g_bad_width
    $error("dclim_top: result width must be 16");
  end

  logic [15:0] lower_limit;
  logic [15:0] upper_limit;
  logic [15:0] irq_mask;
  logic chan_a_under_flag;
  logic chan_a_over_flag;
  logic chan_b_under_flag;
  logic chan_b_over_flag;
  logic [15:0] low_thr;
  logic [15:0] high_thr;
  logic a_under_evt;
  logic a_over_evt;
  logic b_under_evt;
  logic b_over_evt;

  always_comb
  begin
    low_thr = {lower_limit[11:0], dclim_pkg::LOWER_FILL};
    high_thr = {upper_limit[11:0], dclim_pkg::UPPER_FILL};
  end

  dclim_compare #(.WIDTH(RES_WIDTH)) u_cmp_a (
    .pclk(pclk),
    .presetn(presetn),
    .valid(a_valid),
    .result(a_result),
    .low_thr(low_thr),
    .high_thr(high_thr),
    .under_evt(a_under_evt),
    .over_evt(a_over_evt)
  );
  dclim_compare #(.WIDTH(RES_WIDTH)) u_cmp_b (
    .pclk(pclk),
    .presetn(presetn),
    .valid(b_valid),
    .result(b_result),
    .low_thr(low_thr),
    .high_thr(high_thr),
    .under_evt(b_under_evt),
    .over_evt(b_over_evt)
  );

  // apb decode; zero wait states, access phase answered at once
  logic acc;
  logic wr;
  logic rd;
  logic hit;
  logic [15:0] flag_word;
  logic [15:0] rd_word;
  always_comb
  begin
    acc = psel && penable;
    wr = acc && pwrite;
    rd = acc && !pwrite;
    hit = (paddr == dclim_pkg::ADDR_FLAGS) || (paddr == dclim_pkg::ADDR_LOWER) ||
          (paddr == dclim_pkg::ADDR_UPPER) || (paddr == dclim_pkg::ADDR_CTRL) ||
          (paddr == dclim_pkg::ADDR_IRQ_MASK);
    flag_word = 16'h0000;
    flag_word[dclim_pkg::BIT_A_UNDER] = chan_a_under_flag;
    flag_word[dclim_pkg::BIT_A_OVER] = chan_a_over_flag;
    flag_word[dclim_pkg::BIT_B_UNDER] = chan_b_under_flag;
    flag_word[dclim_pkg::BIT_B_OVER] = chan_b_over_flag;
    flag_word[15:12] = dclim_pkg::IDX_FLAGS;
    case (paddr)
      dclim_pkg::ADDR_FLAGS: rd_word = flag_word;
      dclim_pkg::ADDR_LOWER: rd_word = lower_limit;
      dclim_pkg::ADDR_UPPER: rd_word = upper_limit;
      dclim_pkg::ADDR_IRQ_MASK: rd_word = irq_mask;
      default: rd_word = 16'h0000;
    endcase
  end

  // register writes
  logic [15:0] next_lower;
  logic [15:0] next_upper;
  logic [15:0] next_mask;
  logic soft_clr;
  always_comb
  begin
    next_lower = lower_limit;
    next_upper = upper_limit;
    next_mask = irq_mask;
    soft_clr = wr && (paddr == dclim_pkg::ADDR_CTRL) &&
               (pwdata[7:0] == dclim_pkg::SOFT_RESET_CODE);
    if (wr && (paddr == dclim_pkg::ADDR_LOWER))
      next_lower = pwdata[15:0];
    if (wr && (paddr == dclim_pkg::ADDR_UPPER))
      next_upper = pwdata[15:0];
    if (wr && (paddr == dclim_pkg::ADDR_IRQ_MASK))
      next_mask = pwdata[15:0] & dclim_pkg::FLAG_MASK;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lower_limit <= dclim_pkg::LOWER_RESET;
      upper_limit <= dclim_pkg::UPPER_RESET;
      irq_mask <= dclim_pkg::MASK_RESET;
    end
    else
    begin
      lower_limit <= next_lower;
      upper_limit <= next_upper;
      irq_mask <= next_mask;
    end
  end

  // sticky flags: a new event in the clearing cycle wins over the clear
  logic flag_rd;
  logic next_a_under;
  logic next_a_over;
  logic next_b_under;
  logic next_b_over;
  always_comb
  begin
    flag_rd = (rd && (paddr == dclim_pkg::ADDR_FLAGS)) || soft_clr;
    next_a_under = a_under_evt || (chan_a_under_flag && !flag_rd);
    next_a_over = a_over_evt || (chan_a_over_flag && !flag_rd);
    next_b_under = b_under_evt || (chan_b_under_flag && !flag_rd);
    next_b_over = b_over_evt || (chan_b_over_flag && !flag_rd);
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chan_a_under_flag <= 1'b0;
      chan_a_over_flag <= 1'b0;
      chan_b_under_flag <= 1'b0;
      chan_b_over_flag <= 1'b0;
    end
    else
    begin
      chan_a_under_flag <= next_a_under;
      chan_a_over_flag <= next_a_over;
      chan_b_under_flag <= next_b_under;
      chan_b_over_flag <= next_b_over;
    end
  end

  // bus answer and interrupt, all registered
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_irq;
  always_comb
  begin
    // answer lands in the cycle after setup, so access phase sees pready high
    next_pready = psel && !penable;
    next_pslverr = psel && !penable && !hit;
    next_prdata = (psel && !penable && !pwrite) ? {16'h0000, rd_word} : prdata;
    next_irq = |(flag_word & irq_mask & dclim_pkg::FLAG_MASK);
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
    end
  end

  // checks
  property p_b_over;
    @(posedge pclk) disable iff (!presetn)
    (b_valid && b_result > high_thr) |-> ##2 chan_b_over_flag;
  endproperty
  a_b_over: assert property (p_b_over) else $error("b over flag missed");
  property p_b_under;
    @(posedge pclk) disable iff (!presetn)
    (b_valid && b_result < low_thr) |-> ##2 chan_b_under_flag;
  endproperty
  a_b_under: assert property (p_b_under) else $error("b under flag missed");
  property p_a_over;
    @(posedge pclk) disable iff (!presetn)
    (a_valid && a_result > high_thr) |-> ##2 chan_a_over_flag;
  endproperty
  a_a_over: assert property (p_a_over) else $error("a over flag missed");
  property p_a_under;
    @(posedge pclk) disable iff (!presetn)
    (a_valid && a_result < low_thr) |-> ##2 chan_a_under_flag;
  endproperty
  a_a_under: assert property (p_a_under) else $error("a under flag missed");
  property p_sticky;
    @(posedge pclk) disable iff (!presetn)
    ($past(chan_a_over_flag) && !chan_a_over_flag) |-> $past(flag_rd);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without read");
  property p_low_fill;
    @(posedge pclk) disable iff (!presetn)
    low_thr[3:0] == 4'h0 && low_thr[15:4] == lower_limit[11:0];
  endproperty
  a_low_fill: assert property (p_low_fill) else $error("low threshold widening wrong");
  property p_high_fill;
    @(posedge pclk) disable iff (!presetn)
    high_thr[3:0] == 4'hf && high_thr[15:4] == upper_limit[11:0];
  endproperty
  a_high_fill: assert property (p_high_fill) else $error("high threshold widening wrong");
  property p_rdback;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == dclim_pkg::ADDR_UPPER)
      |=> prdata[15:0] == $past(upper_limit);
  endproperty
  a_rdback: assert property (p_rdback) else $error("upper limit readback wrong");
  property p_soft;
    @(posedge pclk) disable iff (!presetn)
    soft_clr |=> $stable(lower_limit) && $stable(upper_limit);
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset touched limits");
  property p_no_cross;
    @(posedge pclk) disable iff (!presetn)
    ($rose(chan_a_over_flag) || $rose(chan_a_under_flag)) |-> $past(a_valid, 2);
  endproperty
  a_no_cross: assert property (p_no_cross) else $error("a flag set with no a result");
  property p_b_no_cross;
    @(posedge pclk) disable iff (!presetn)
    ($rose(chan_b_over_flag) || $rose(chan_b_under_flag)) |-> $past(b_valid, 2);
  endproperty
  a_b_no_cross: assert property (p_b_no_cross) else $error("b flag set with no b result");
  property p_rd_clear;
    @(posedge pclk) disable iff (!presetn)
    (rd && paddr == dclim_pkg::ADDR_FLAGS && !a_over_evt) |=> !chan_a_over_flag;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("a over flag kept after read");
  property p_soft_clr;
    @(posedge pclk) disable iff (!presetn)
    (soft_clr && !b_under_evt) |=> !chan_b_under_flag;
  endproperty
  a_soft_clr: assert property (p_soft_clr) else $error("b under flag kept after soft reset");
  property p_irq_on;
    @(posedge pclk) disable iff (!presetn)
    (|(flag_word & irq_mask)) |=> irq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("interrupt missing for unmasked flag");
  property p_irq_off;
    @(posedge pclk) disable iff (!presetn)
    !(|(flag_word & irq_mask)) |=> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt raised with no unmasked flag");
  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held longer than one cycle");
  property p_err_ready;
    @(posedge pclk) disable iff (!presetn)
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error response without ready");
  c_b_over: cover property (@(posedge pclk) disable iff (!presetn) chan_b_over_flag);
  c_a_under: cover property (@(posedge pclk) disable iff (!presetn) chan_a_under_flag);
  c_clear: cover property (@(posedge pclk) disable iff (!presetn)
    chan_a_over_flag ##1 !chan_a_over_flag);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
endmodule // dclim_top
`default_nettype wire

// ==== sim/dclim_host.sv ====
// apb host model issuing register transfers to the limit block
`timescale 1ns/1ps
`default_nettype none
module dclim_host (
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [11:0] paddr,
  output var logic [31:0] pwdata
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  // request held until pready seen at an edge; idle edge before the next setup
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    int n;
    begin
      q = 32'h0;
      e = 1'b0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++)
      begin
        @(posedge pclk);
        if (pready === 1'b1)
          break;
      end
      if (n == 16)
      begin
        tb_top.n_mismatch++;
        tb_top.test_done();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
endmodule // dclim_host
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench for the dual channel limit alert block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic a_valid = 1'b0;
  logic b_valid = 1'b0;
  logic [15:0] a_result = 16'h0000;
  logic [15:0] b_result = 16'h0000;
  int n_mismatch = 0;
  int cmp_count = 0;
  // under edge, plain, plain, over edge for lower 0x123 and upper 0x456
  logic [15:0] vals [4] = '{16'h122f, 16'h1230, 16'h456f, 16'h4570};
  logic [31:0] fa [4] = '{32'h3001, 32'h3000, 32'h3000, 32'h3002};
  int c, i;
  always #25 pclk = ~pclk;
  dclim_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .a_valid(a_valid), .a_result(a_result), .b_valid(b_valid),
    .b_result(b_result), .irq(irq));
  dclim_host u_host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    u_host.xfer(1'b0, a, 32'h0, q, e);
    chk(q, exp);
    chk({31'h0, e}, 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    u_host.xfer(1'b1, a, d, q, e);
    chk({31'h0, e}, 32'h0);
  endtask
  // one-cycle valid pulse, then time for the flag to land
  task automatic conv(input int ch, input logic [15:0] v);
    @(posedge pclk);
    if (ch == 0)
    begin
      a_valid <= 1'b1;
      a_result <= v;
    end
    else
    begin
      b_valid <= 1'b1;
      b_result <= v;
    end
    @(posedge pclk);
    a_valid <= 1'b0;
    b_valid <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic test_done();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    logic [31:0] q;
    logic e;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(dclim_pkg::ADDR_LOWER, 32'h0800);
    rd(dclim_pkg::ADDR_UPPER, 32'h07ff);
    rd(dclim_pkg::ADDR_FLAGS, 32'h3000);
    wr(dclim_pkg::ADDR_LOWER, 32'h4123);
    wr(dclim_pkg::ADDR_UPPER, 32'h5456);
    rd(dclim_pkg::ADDR_LOWER, 32'h4123);
    rd(dclim_pkg::ADDR_UPPER, 32'h5456);
    for (c = 0; c < 2; c++)
      for (i = 0; i < 4; i++)
      begin
        conv(c, vals[i]);
        // flags of the other channel must stay clear
        rd(dclim_pkg::ADDR_FLAGS, (c == 0) ? fa[i] : ((fa[i] & 32'h3) << 4) | 32'h3000);
      end
    conv(0, 16'h0000);
    conv(0, 16'h3000);
    rd(dclim_pkg::ADDR_FLAGS, 32'h3001);
    rd(dclim_pkg::ADDR_FLAGS, 32'h3000);
    wr(dclim_pkg::ADDR_IRQ_MASK, 32'h0033);
    conv(1, 16'hffff);
    chk({31'h0, irq}, 32'h1);
    rd(dclim_pkg::ADDR_FLAGS, 32'h3020);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(dclim_pkg::ADDR_IRQ_MASK, 32'h0001);
    conv(1, 16'hffff);
    chk({31'h0, irq}, 32'h0);
    conv(0, 16'h0000);
    chk({31'h0, irq}, 32'h1);
    conv(1, 16'h0000);
    wr(dclim_pkg::ADDR_CTRL, 32'h003c);
    rd(dclim_pkg::ADDR_FLAGS, 32'h3000);
    rd(dclim_pkg::ADDR_LOWER, 32'h4123);
    u_host.xfer(1'b0, 12'h040, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(dclim_pkg::ADDR_LOWER, 32'h0800);
    rd(dclim_pkg::ADDR_UPPER, 32'h07ff);
    test_done();
  end
endmodule // tb_top
`default_nettype wire
